// ---- verilog/angle_sensor_serial_uvw_otp.sv ----
// Overview of operation
// - Serial words go out MSB first
// - Load fresh angle every 2 us
// - Buffer holds while chip select low
// - No minimum clock rate, no timeout
// - Full transaction is 16 clock pulses
// - Short reads under 8 pulses tolerated
// - Fast rereads return same stored angle
// - Three 50 percent outputs, 60 degrees apart
// - Commutation uses live corrected angle, not the held buffer
// - Burn bit n stores register n
// - Burned register loads at power-up, locks
// - Write frame: 0010, address, data
// - Read frame: 0001, address, ignored byte
// - Read returns angle then register byte
// - Output angle is raw minus offset
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_serial_uvw_otp (
  // System clock and control
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic otp_blank_n,
  // Front-end angle, same clock
  input wire logic [angle_pkg::ANG_W-1:0] raw_angle,
  // Serial link
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Commutation outputs
  output logic commutation_u,
  output logic commutation_v,
  output logic commutation_w
);
  import angle_pkg::*;

  // ****************************************
  // System domain state
  // ****************************************
  logic cs_meta_reg, cs_sync_reg;
  logic tgl_meta_reg, tgl_sync_reg, tgl_prev_reg;
  logic [CNT_W-1:0] refresh_cnt_reg;
  logic [ANG_W-1:0] angle_corr_reg;
  logic [ANG_W-1:0] out_buf_reg;
  logic load_pend_reg;
  logic [ANG_W-1:0] prog_reg [PROG_REGS];
  logic [PROG_REGS-1:0] burned;
  logic [PROG_REGS*ANG_W-1:0] fuse_bits;
  logic [PROG_REGS*ANG_W-1:0] prog_flat;

  // ****************************************
  // Link domain state
  // ****************************************
  logic [3:0] rise_cnt_reg;
  logic [3:0] fall_cnt_reg;
  logic [FRAME_BITS-1:0] rx_sh_reg;
  logic [FRAME_BITS-1:0] rx_word_reg;
  logic [ANG_W-1:0] head_reg;
  logic head_ok_reg;
  logic done_tgl_reg;

  // ****************************************
  // Command decode
  // ****************************************
  wire frame_evt = tgl_sync_reg ^ tgl_prev_reg;
  wire [3:0] rx_cmd = rx_word_reg[CMD_MSB:CMD_LSB];
  wire [3:0] rx_addr = rx_word_reg[ADDR_MSB:ADDR_LSB];
  wire [ANG_W-1:0] rx_data = rx_word_reg[ANG_W-1:0];
  wire wr_evt = frame_evt && (rx_cmd == CMD_WRITE);
  wire prog_addr = (rx_addr < 4'(PROG_REGS));
  wire burn_wr = wr_evt && (rx_addr == FUSE_BURN_CONTROL);
  wire one_hot = (rx_data != NO_DATA) && ((rx_data & (rx_data - 8'h01)) == NO_DATA);
  wire burn_en = burn_wr && one_hot;
  logic [IDX_W-1:0] burn_idx;
  always_comb begin
    burn_idx = '0;
    for (int k = 0; k < PROG_REGS; k++) begin
      if (rx_data[k]) begin
        burn_idx = IDX_W'(k);
      end
    end
  end
  wire frozen = !cs_sync_reg;
  wire refresh_tick = (refresh_cnt_reg == REFRESH_LAST);
  wire [ANG_W-1:0] zero_offset = prog_reg[ZERO_OFFSET_REG[IDX_W-1:0]];
  wire [ANG_W-1:0] angle_next = raw_angle - zero_offset;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
    end else if (ce) begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      tgl_meta_reg <= done_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_prev_reg <= tgl_sync_reg;
    end
  end

  // ****************************************
  // Refresh and output buffer
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      refresh_cnt_reg <= '0;
      angle_corr_reg <= REG_RESET;
      out_buf_reg <= REG_RESET;
    end else if (ce) begin
      refresh_cnt_reg <= refresh_tick ? '0 : refresh_cnt_reg + 1'b1;
      angle_corr_reg <= angle_next;
      if (refresh_tick && !frozen) begin
        out_buf_reg <= angle_corr_reg;
      end
    end
  end

  // ****************************************
  // Commutation outputs
  // ****************************************
  // Sector = angle * 6 / 256, each sector 60 degrees
  wire [10:0] ang_x6 = {1'b0, angle_corr_reg, 2'b00} + {2'b00, angle_corr_reg, 1'b0};
  wire [2:0] sector = ang_x6[10:8];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      commutation_u <= 1'b0;
      commutation_v <= 1'b0;
      commutation_w <= 1'b0;
    end else if (ce) begin
      commutation_u <= (sector < SECTOR_U_END);
      commutation_v <= (sector >= SECTOR_V_LO) && (sector <= SECTOR_V_HI);
      commutation_w <= (sector >= SECTOR_W_LO) && (sector <= SECTOR_W_HI);
    end
  end

  // ****************************************
  // Programmable registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      load_pend_reg <= 1'b1;
    end else if (ce) begin
      load_pend_reg <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PROG_REGS; i++) begin : g_prog
      wire wr_hit = wr_evt && prog_addr && (rx_addr[IDX_W-1:0] == IDX_W'(i));
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          prog_reg[i] <= REG_RESET;
        end else if (ce) begin
          if (load_pend_reg) begin
            // Power-up copy of fuse contents
            prog_reg[i] <= burned[i] ? fuse_bits[i*ANG_W +: ANG_W] : REG_RESET;
          end else if (wr_hit && !burned[i]) begin
            prog_reg[i] <= rx_data;
          end
        end
      end
      assign prog_flat[i*ANG_W +: ANG_W] = prog_reg[i];
    end
  endgenerate

  fuse_store u_fuse (
    .sys_clk(sys_clk),
    .otp_blank_n(otp_blank_n),
    .ce(ce),
    .burn_en(burn_en),
    .burn_idx(burn_idx),
    .burn_data(prog_flat),
    .burned(burned),
    .fuse_bits(fuse_bits)
  );

  // ****************************************
  // Read-back mux, quasi-static during a frame
  // ****************************************
  wire [3:0] head_addr = head_reg[3:0];
  wire [ANG_W-1:0] read_val =
    (head_addr < 4'(PROG_REGS)) ? prog_reg[head_addr[IDX_W-1:0]] :
    (head_addr == FUSE_BURN_CONTROL) ? burned : NO_DATA;
  wire head_is_read = head_ok_reg && (head_reg[7:4] == CMD_READ);
  wire [ANG_W-1:0] resp_byte = head_is_read ? read_val : NO_DATA;
  wire [FRAME_BITS-1:0] tx_word = {out_buf_reg, resp_byte};

  // ****************************************
  // Link receive, rising edge
  // ****************************************
  // Chip select high clears the counter, shift register and header; no timeout exists
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_reg <= '0;
      rx_sh_reg <= '0;
      head_reg <= REG_RESET;
      head_ok_reg <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_reg + 1'b1;
      rx_sh_reg <= {rx_sh_reg[FRAME_BITS-2:0], mosi};
      if (rise_cnt_reg == RISE_HEAD_LAST) begin
        head_reg <= {rx_sh_reg[ANG_W-2:0], mosi};
        head_ok_reg <= 1'b1;
      end
    end
  end

  // Word and toggle survive chip select so the system side can take them
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      rx_word_reg <= '0;
      done_tgl_reg <= 1'b0;
    end else if (!cs_n && rise_cnt_reg == RISE_FRAME_LAST) begin
      rx_word_reg <= {rx_sh_reg[FRAME_BITS-2:0], mosi};
      done_tgl_reg <= !done_tgl_reg;
    end
  end

  // ****************************************
  // Link transmit, falling edge
  // ****************************************
  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      fall_cnt_reg <= '0;
    end else begin
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end
  end

  // Bit 15 leaves first; the counter only indexes the word
  assign miso = tx_word[~fall_cnt_reg];

  // ****************************************
  // Checks
  // ****************************************
  chk_buf_frozen: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ce && frozen) |=> $stable(out_buf_reg))
    else $error("output buffer changed while frozen");

  chk_refresh_load: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ce && refresh_tick && !frozen) |=> (out_buf_reg == $past(angle_corr_reg)))
    else $error("refresh did not load buffer");

  chk_same_angle: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (refresh_cnt_reg != REFRESH_LAST) |=> $stable(out_buf_reg))
    else $error("buffer changed between refreshes");

  chk_zero_sub: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ce |=> (angle_corr_reg == ANG_W'($past(raw_angle) - $past(zero_offset))))
    else $error("corrected angle wrong");

  chk_uvw_half: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ce |=> (commutation_u == ($past(angle_corr_reg) < 8'h80)) &&
      (commutation_v != commutation_w || $past(sector) == 3'h0 || $past(sector) == 3'h5 ||
       $past(sector) == 3'h2 || $past(sector) == 3'h3))
    else $error("commutation pattern wrong");

  chk_write_apply: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ce && !load_pend_reg && wr_evt && rx_addr == ZERO_OFFSET_REG &&
     !burned[ZERO_OFFSET_REG[IDX_W-1:0]]) |=> (zero_offset == $past(rx_data)))
    else $error("register write not applied");

  chk_burned_lock: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ce && !load_pend_reg && burned[ZERO_OFFSET_REG[IDX_W-1:0]]) |=> $stable(zero_offset))
    else $error("burned register was written");

  chk_burn_single: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ce && burn_wr && rx_data == 8'h10) |=> burned[ZERO_OFFSET_REG[IDX_W-1:0]])
    else $error("burn of register 4 not taken");

  chk_msb_first: assert property (
    @(posedge link_clk) disable iff (cs_n)
    (fall_cnt_reg == 4'h0) |-> (miso == out_buf_reg[ANG_W-1]))
    else $error("first bit is not angle msb");

  chk_frame_done: assert property (
    @(negedge link_clk) disable iff (cs_n || !nrst)
    (fall_cnt_reg == 4'hf) |-> (done_tgl_reg != $past(done_tgl_reg)))
    else $error("frame end not signalled");
endmodule // angle_sensor_serial_uvw_otp
`default_nettype wire

// ---- verilog/angle_pkg.sv ----
`default_nettype none
package angle_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ANG_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int PROG_REGS = 8;
  localparam int IDX_W = 3;
  localparam int CNT_W = 6;

  // ****************************************
  // Serial command frame layout
  // ****************************************
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] RISE_HEAD_LAST = 4'h7;
  localparam logic [3:0] RISE_FRAME_LAST = 4'hf;

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [3:0] ZERO_OFFSET_REG = 4'h4;
  localparam logic [3:0] ZERO_HIGH_REG = 4'h5;
  localparam logic [3:0] FUSE_BURN_CONTROL = 4'h9;
  localparam logic [ANG_W-1:0] REG_RESET = 8'h00;
  localparam logic [ANG_W-1:0] NO_DATA = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_NS = 40;
  localparam int REFRESH_NS = 2000;
  localparam int REFRESH_CYCLES = REFRESH_NS / SYS_CLK_NS;
  localparam logic [CNT_W-1:0] REFRESH_LAST = CNT_W'(REFRESH_CYCLES - 1);

  // ****************************************
  // Commutation sectors of 60 degrees
  // ****************************************
  localparam logic [2:0] SECTOR_U_END = 3'h3;
  localparam logic [2:0] SECTOR_V_LO = 3'h1;
  localparam logic [2:0] SECTOR_V_HI = 3'h3;
  localparam logic [2:0] SECTOR_W_LO = 3'h2;
  localparam logic [2:0] SECTOR_W_HI = 3'h4;
endpackage
`default_nettype wire

// ---- verilog/fuse_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module fuse_store (
  // Clock and blank state
  input wire logic sys_clk,
  input wire logic otp_blank_n,
  input wire logic ce,
  // Burn request
  input wire logic burn_en,
  input wire logic [angle_pkg::IDX_W-1:0] burn_idx,
  input wire logic [angle_pkg::PROG_REGS*angle_pkg::ANG_W-1:0] burn_data,
  // Fuse contents
  output logic [angle_pkg::PROG_REGS-1:0] burned,
  output logic [angle_pkg::PROG_REGS*angle_pkg::ANG_W-1:0] fuse_bits
);
  import angle_pkg::*;

  // ****************************************
  // One fuse word per programmable register
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < PROG_REGS; i++) begin : g_fuse
      wire hit = burn_en && (burn_idx == IDX_W'(i)) && !burned[i];
      always_ff @(posedge sys_clk or negedge otp_blank_n) begin
        if (!otp_blank_n) begin
          burned[i] <= 1'b0;
          fuse_bits[i*ANG_W +: ANG_W] <= REG_RESET;
        end else if (ce && hit) begin
          // Burn is permanent: a burned word never changes again
          burned[i] <= 1'b1;
          fuse_bits[i*ANG_W +: ANG_W] <= burn_data[i*ANG_W +: ANG_W];
        end
      end
    end
  endgenerate

  chk_burn_sticks: assert property (
    @(posedge sys_clk) disable iff (!otp_blank_n)
    burned[ZERO_OFFSET_REG[IDX_W-1:0]] |=>
      burned[ZERO_OFFSET_REG[IDX_W-1:0]] &&
      $stable(fuse_bits[ZERO_OFFSET_REG*ANG_W +: ANG_W]))
    else $error("burned fuse word changed");
endmodule // fuse_store
`default_nettype wire

// ---- testbench/serial_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
  // Serial link
  output logic link_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ****************************************
  // One frame of n pulses, returned bits right-aligned
  // ****************************************
  task automatic xfer(input logic [15:0] tx, input int n, input int half,
                      output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    mosi = tx[15];
    // Let the device freeze its buffer before the first pulse
    #160;
    for (int i = 0; i < n; i++) begin
      rx = {rx[14:0], miso};
      link_clk = 1'b1;
      #half;
      link_clk = 1'b0;
      if (i < 15) mosi = tx[14-i];
      #half;
    end
    cs_n = 1'b1;
    // Deselected input carries no stale value
    mosi = ~mosi;
    #200;
  endtask
endmodule // serial_master_model
`default_nettype wire

// ---- testbench/tb_angle_sensor_serial_uvw_otp.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_angle_sensor_serial_uvw_otp;
  import angle_pkg::*;
  logic sys_clk, nrst, ce, otp_blank_n, link_clk, cs_n, mosi, miso, cu, cv, cw;
  logic [ANG_W-1:0] raw_angle, offset, v5, exp_a;
  logic [15:0] rx;
  logic [31:0] seed;
  int n_errors, checked;

  angle_sensor_serial_uvw_otp dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .otp_blank_n(otp_blank_n), .raw_angle(raw_angle), .link_clk(link_clk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .commutation_u(cu),
    .commutation_v(cv), .commutation_w(cw));
  serial_master_model master (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [2:0] exp_uvw(input logic [7:0] a);
    logic [10:0] p;
    logic [2:0] s;
    p = 11'(a) * 11'd6;
    s = p[10:8];
    return {s < 3'h3, s >= 3'h1 && s <= 3'h3, s >= 3'h2 && s <= 3'h4};
  endfunction

  task automatic end_of_test;
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_frame(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_uvw(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [3:0] cmd, input logic [3:0] addr,
                       input logic [7:0] d, input int n, input int half);
    master.xfer({cmd, addr, d}, n, half, rx);
  endtask

  task automatic rdreg(input logic [3:0] addr, input logic [7:0] exp);
    frame(CMD_READ, addr, 8'h00, 16, 15);
    cmp_frame({8'h00, rx[7:0]}, {8'h00, exp});
  endtask

  task automatic settle;
    repeat (60) @(negedge sys_clk);
    exp_a = raw_angle - offset;
  endtask

  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    otp_blank_n = 1'b0;
    ce = 1'b1;
    raw_angle = 8'h00;
    offset = 8'h00;
    seed = 32'd84624;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    otp_blank_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      @(negedge sys_clk);
      raw_angle = (i == 0) ? 8'hff : seed[7:0];
      if (i == 4) begin
        offset = seed[15:8];
        frame(CMD_WRITE, ZERO_OFFSET_REG, offset, 16, 15);
        rdreg(ZERO_OFFSET_REG, offset);
      end
      settle();
      frame(4'h0, 4'h0, 8'h00, 16, 15);
      cmp_frame(rx, {exp_a, NO_DATA});
      frame(4'h0, 4'h0, 8'h00, (i % 6) + 2, 15);
      cmp_frame(rx, 16'(exp_a >> (6 - (i % 6))));
      frame(CMD_READ, ZERO_OFFSET_REG, 8'h00, 16, 15);
      cmp_frame(rx, {exp_a, offset});
    end
    // Angle must not move during a very slow frame
    fork
      frame(4'h0, 4'h0, 8'h00, 16, 1000);
      begin
        #400;
        @(negedge sys_clk);
        raw_angle = ~raw_angle;
      end
    join
    cmp_frame(rx, {exp_a, NO_DATA});
    settle();
    frame(4'h0, 4'h0, 8'h00, 16, 15);
    cmp_frame(rx, {exp_a, NO_DATA});
    for (int a = 0; a < 256; a++) begin
      @(negedge sys_clk);
      raw_angle = a[7:0];
      repeat (4) @(negedge sys_clk);
      cmp_uvw({cu, cv, cw}, exp_uvw(raw_angle - offset));
    end
    // Clock enable low freezes the commutation outputs
    ce = 1'b0;
    raw_angle = 8'h00;
    repeat (4) @(negedge sys_clk);
    cmp_uvw({cu, cv, cw}, exp_uvw(8'hff - offset));
    ce = 1'b1;
    // ****************************************
    // Fuse burning and power cycle
    // ****************************************
    v5 = seed[23:16];
    frame(CMD_WRITE, ZERO_HIGH_REG, v5, 16, 15);
    rdreg(ZERO_HIGH_REG, v5);
    frame(CMD_WRITE, FUSE_BURN_CONTROL, 8'h30, 16, 15);
    rdreg(FUSE_BURN_CONTROL, 8'h00);
    frame(CMD_WRITE, FUSE_BURN_CONTROL, 8'h10, 16, 15);
    rdreg(FUSE_BURN_CONTROL, 8'h10);
    frame(CMD_WRITE, FUSE_BURN_CONTROL, 8'h20, 16, 15);
    rdreg(FUSE_BURN_CONTROL, 8'h30);
    frame(CMD_WRITE, ZERO_OFFSET_REG, ~offset, 16, 15);
    rdreg(ZERO_OFFSET_REG, offset);
    frame(CMD_WRITE, 4'h3, seed[31:24], 16, 15);
    rdreg(4'h3, seed[31:24]);
    rdreg(4'ha, 8'h00);
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rdreg(ZERO_OFFSET_REG, offset);
    rdreg(ZERO_HIGH_REG, v5);
    rdreg(4'h3, REG_RESET);
    settle();
    frame(4'h0, 4'h0, 8'h00, 16, 15);
    cmp_frame(rx, {exp_a, NO_DATA});
    end_of_test();
  end
endmodule // tb_angle_sensor_serial_uvw_otp
`default_nettype wire
